/* dis_defs.svh */
// constants of the drive input signal block
`ifndef DIS_DEFS_SVH
`define DIS_DEFS_SVH
// ----------------------------------------
// terminals and function codes
// ----------------------------------------
`define DIS_NTERM 5
`define DIS_FN_RL 8'h00
`define DIS_FN_RM 8'h01
`define DIS_FN_RH 8'h02
`define DIS_FN_RT 8'h03
`define DIS_FN_AU 8'h04
`define DIS_FN_JOG 8'h05
`define DIS_FN_REX 8'h08
`define DIS_FN_X10 8'h0a
`define DIS_FN_X12 8'h0c
`define DIS_FN_X14 8'h0e
`define DIS_FN_X18 8'h12
`define DIS_FN_SHUT 8'h18
`define DIS_FN_STF 8'h3c
`define DIS_FN_STR 8'h3d
`define DIS_TF_RST0 32'h0201_3d3c
`define DIS_TF_RST1 32'h0000_0001
// ----------------------------------------
// register map
// ----------------------------------------
`define DIS_A_CTRL 8'h00
`define DIS_A_TF0 8'h04
`define DIS_A_TF1 8'h08
`define DIS_A_NET 8'h0c
`define DIS_A_STAT 8'h10
`define DIS_A_PAR 8'h14
`define DIS_A_MOT 8'h18
`define DIS_CTRL_RST 32'h0000_0000
`define DIS_AXI_OKAY 2'h0
`define DIS_AXI_SLVERR 2'h2
// ----------------------------------------
// selection values
// ----------------------------------------
`define DIS_SHUT_NO 3'h0
`define DIS_SHUT_NC 3'h2
`define DIS_SHUT_MIX 3'h4
`define DIS_OPMODE_IL 3'h7
// ----------------------------------------
// parameter numbers, first and second set
// ----------------------------------------
`define DIS_PR_ACC1 16'h0007
`define DIS_PR_DEC1 16'h0008
`define DIS_PR_MOT1 16'h0047
`define DIS_PR_ACC2 16'h002c
`define DIS_PR_DEC2A 16'h002c
`define DIS_PR_DEC2B 16'h002d
`define DIS_PR_MOT2 16'h01c2
// ----------------------------------------
// timing
// ----------------------------------------
`define DIS_CLK_MHZ 200
`define DIS_FILT_NS 10000
`define DIS_FILT_CYC ((`DIS_FILT_NS * `DIS_CLK_MHZ + 999) / 1000)
`define DIS_FCNT_W 11
`endif

/* dis_pkg.sv */
// types of the drive input signal block
`default_nettype none
package dis_pkg;
  typedef enum logic [1:0] {
    DIS_SRC_ANALOG,
    DIS_SRC_PID,
    DIS_SRC_MULTI,
    DIS_SRC_JOG
  } dis_speed_src_e;
  typedef logic [7:0] dis_fcode_t;
endpackage
`default_nettype wire

/* dis_term_if.sv */
// carrier between terminal conditioning and the main block
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
interface dis_term_if;
  logic [`DIS_NTERM-1:0] raw;
  logic [`DIS_NTERM-1:0] clean;
  modport cond (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

/* dis_filter.sv */
// terminal synchroniser and debounce filter
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // terminals
  dis_term_if.cond trm
);
  genvar g;
  generate
    for (g = 0; g < `DIS_NTERM; g = g + 1) begin : g_term
      logic s1_r;
      logic s2_r;
      logic out_r;
      logic [`DIS_FCNT_W-1:0] cnt_r;
      wire logic differs = (s2_r != out_r);
      wire logic settled = (cnt_r == `DIS_FCNT_W'(`DIS_FILT_CYC - 1));
      // a level must hold the whole window; short enough for 2 ms response
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          out_r <= 1'b0;
          cnt_r <= '0;
        end else begin
          s1_r <= trm.raw[g];
          s2_r <= s1_r;
          cnt_r <= (differs && !settled) ? cnt_r + 1'b1 : '0;
          if (differs && settled) begin
            out_r <= s2_r;
          end
        end
      end
      assign trm.clean[g] = out_r;
    end
  endgenerate
endmodule // dis_filter
`default_nettype wire

/* dis_top.sv */
// drive input signal conditioning, priority and shutoff gating
// How it works
// - same function on several terminals is ORed
// - speed priority: jog, multi-speed, then PID
// - shutoff stands in for missing permit, and for missing interlock in operation mode 7 only
// - seventh speed and remote setting share signals
// - V/F switchover also selects second set
// - control method frozen while running
// - current-input select disables voltage input
// - permit/shutoff within 2ms, others 20ms
// - shutoff while running cuts output at once
// - no start while shutoff asserted
// - start removal decelerates, shutoff coasts
// - setting 2 makes shutoff normally closed
// - setting 4: terminal NC, network NO
// - enable table for settings 0, 2, 4
// - shutoff works in every operation mode
// - second-set select uses second parameters
// - second set swaps accel, decel, motor parameters
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // contacts and drive state
  input wire logic [`DIS_NTERM-1:0] terminal_pin,
  input wire logic drive_running,
  // to output stage and parameter selection
  output logic output_enable,
  output logic coast_stop,
  output logic decel_stop,
  output logic second_set_active,
  output logic vf_control,
  output logic [1:0] speed_source,
  output logic [3:0] speed_step,
  output logic remote_accel,
  output logic remote_decel,
  output logic remote_clear,
  output logic voltage_input_valid,
  output logic run_permit_ok,
  output logic panel_interlock_active
);
  // ----------------------------------------
  // terminal conditioning
  // ----------------------------------------
  dis_term_if trm ();
  assign trm.raw = terminal_pin;
  dis_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .trm(trm)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] tf0_r;
  logic [31:0] tf1_r;
  logic [31:0] net_r;
  wire logic [2:0] shutoff_logic_select = ctrl_r[2:0];
  wire logic [2:0] operation_mode_select = ctrl_r[6:4];
  wire logic remote_en = ctrl_r[8];
  wire logic decel2_own = ctrl_r[9];
  wire logic net_shutoff = net_r[0];
  wire logic net_fwd = net_r[1];
  wire logic net_rev = net_r[2];
  dis_pkg::dis_fcode_t terminal_function_select [`DIS_NTERM];
  assign terminal_function_select[0] = tf0_r[7:0];
  assign terminal_function_select[1] = tf0_r[15:8];
  assign terminal_function_select[2] = tf0_r[23:16];
  assign terminal_function_select[3] = tf0_r[31:24];
  assign terminal_function_select[4] = tf1_r[7:0];

  // ----------------------------------------
  // function merge
  // ----------------------------------------
  // per function: assigned somewhere, and ORed level
  logic [11:0] fn_asg;
  logic [11:0] fn_lvl;
  localparam int NFN = 12;
  localparam logic [7:0] FN_CODE [NFN] = '{`DIS_FN_RL, `DIS_FN_RM,
    `DIS_FN_RH, `DIS_FN_RT, `DIS_FN_AU, `DIS_FN_JOG, `DIS_FN_REX,
    `DIS_FN_X10, `DIS_FN_X12, `DIS_FN_X14, `DIS_FN_X18, `DIS_FN_SHUT};
  genvar f;
  generate
    for (f = 0; f < NFN; f = f + 1) begin : g_fn
      logic [`DIS_NTERM-1:0] hit;
      genvar t;
      for (t = 0; t < `DIS_NTERM; t = t + 1) begin : g_t
        assign hit[t] = (terminal_function_select[t] == FN_CODE[f]);
      end
      assign fn_asg[f] = |hit;
      assign fn_lvl[f] = |(hit & trm.clean);
    end
  endgenerate
  wire logic [`DIS_NTERM-1:0] stf_hit;
  wire logic [`DIS_NTERM-1:0] str_hit;
  genvar s;
  generate
    for (s = 0; s < `DIS_NTERM; s = s + 1) begin : g_st
      assign stf_hit[s] = (terminal_function_select[s] == `DIS_FN_STF);
      assign str_hit[s] = (terminal_function_select[s] == `DIS_FN_STR);
    end
  endgenerate
  wire logic sig_rl = fn_lvl[0];
  wire logic sig_rm = fn_lvl[1];
  wire logic sig_rh = fn_lvl[2];
  wire logic second_set_select = fn_lvl[3];
  wire logic current_input_select = fn_lvl[4];
  wire logic sig_jog = fn_lvl[5];
  wire logic fifteen_speed_select = fn_lvl[6];
  wire logic run_permit = fn_lvl[7];
  wire logic panel_interlock = fn_lvl[8];
  wire logic pid_enable_in = fn_lvl[9];
  wire logic vf_switchover = fn_lvl[10];
  wire logic output_shutoff_in = fn_lvl[11];
  wire logic start_fwd = |(stf_hit & trm.clean) | net_fwd;
  wire logic start_rev = |(str_hit & trm.clean) | net_rev;

  // ----------------------------------------
  // shutoff logic
  // ----------------------------------------
  // unknown settings fall back to plain normally open, the safe default
  wire logic en_no = !output_shutoff_in && !net_shutoff;
  wire logic en_nc = output_shutoff_in && net_shutoff;
  wire logic en_mix = output_shutoff_in && !net_shutoff;
  wire logic op_enabled =
    (shutoff_logic_select == `DIS_SHUT_NC) ? en_nc :
    (shutoff_logic_select == `DIS_SHUT_MIX) ? en_mix : en_no;
  // no operation-mode term here: shutoff acts in all modes
  wire logic shut_act = !op_enabled;
  wire logic permit_shared = !fn_asg[7];
  wire logic ilock_shared = !fn_asg[8] &&
    (operation_mode_select == `DIS_OPMODE_IL);
  wire logic permit_nxt = permit_shared ? op_enabled : run_permit;
  wire logic ilock_nxt = ilock_shared ? shut_act : panel_interlock;

  // ----------------------------------------
  // run gating
  // ----------------------------------------
  wire logic start_cmd = start_fwd ^ start_rev;
  wire logic enable_nxt = start_cmd && !shut_act && permit_nxt;
  wire logic coast_nxt = shut_act || !permit_nxt;
  wire logic decel_nxt = !start_cmd && !coast_nxt && drive_running;

  // ----------------------------------------
  // speed priority
  // ----------------------------------------
  // remote mode turns RL/RM/RH into remote keys, FIFTEEN_SPEED_SELECT still steps speed
  wire logic ms_rl = sig_rl && !remote_en;
  wire logic ms_rm = sig_rm && !remote_en;
  wire logic ms_rh = sig_rh && !remote_en;
  wire logic [3:0] step_nxt = {fifteen_speed_select, ms_rh, ms_rm, ms_rl};
  wire dis_pkg::dis_speed_src_e src_nxt =
    sig_jog ? dis_pkg::DIS_SRC_JOG :
    (|step_nxt) ? dis_pkg::DIS_SRC_MULTI :
    pid_enable_in ? dis_pkg::DIS_SRC_PID : dis_pkg::DIS_SRC_ANALOG;

  // ----------------------------------------
  // second set and control method
  // ----------------------------------------
  logic vf_r;
  // a change requested while running only swaps parameters
  wire logic vf_nxt = drive_running ? vf_r : vf_switchover;
  wire logic second_nxt = second_set_select || vf_switchover;
  wire logic [15:0] acc_par =
    second_nxt ? `DIS_PR_ACC2 : `DIS_PR_ACC1;
  wire logic [15:0] dec_par = !second_nxt ? `DIS_PR_DEC1 :
    decel2_own ? `DIS_PR_DEC2B : `DIS_PR_DEC2A;
  wire logic [15:0] mot_par =
    second_nxt ? `DIS_PR_MOT2 : `DIS_PR_MOT1;

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_enable <= 1'b0;
      coast_stop <= 1'b1;
      decel_stop <= 1'b0;
      second_set_active <= 1'b0;
      vf_r <= 1'b0;
      speed_source <= 2'h0;
      speed_step <= 4'h0;
      remote_accel <= 1'b0;
      remote_decel <= 1'b0;
      remote_clear <= 1'b0;
      voltage_input_valid <= 1'b1;
      run_permit_ok <= 1'b0;
      panel_interlock_active <= 1'b0;
    end else begin
      output_enable <= enable_nxt;
      coast_stop <= coast_nxt;
      decel_stop <= decel_nxt;
      second_set_active <= second_nxt;
      vf_r <= vf_nxt;
      speed_source <= src_nxt;
      speed_step <= step_nxt;
      remote_accel <= sig_rh && remote_en;
      remote_decel <= sig_rm && remote_en;
      remote_clear <= sig_rl && remote_en;
      voltage_input_valid <= !current_input_select;
      run_permit_ok <= permit_nxt;
      panel_interlock_active <= ilock_nxt;
    end
  end
  assign vf_control = vf_r;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [7:0] ar_addr_r;
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire logic do_wr = aw_full_r && w_full_r && !s_axi_bvalid;
  wire logic [31:0] bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire logic wr_ctrl = do_wr && (aw_addr_r == `DIS_A_CTRL);
  wire logic wr_tf0 = do_wr && (aw_addr_r == `DIS_A_TF0);
  wire logic wr_tf1 = do_wr && (aw_addr_r == `DIS_A_TF1);
  wire logic wr_net = do_wr && (aw_addr_r == `DIS_A_NET);
  wire logic wr_hit = wr_ctrl || wr_tf0 || wr_tf1 || wr_net;
  wire logic [31:0] stat_word = {12'h000, trm.clean, shut_act,
    voltage_input_valid, run_permit_ok, panel_interlock_active,
    speed_step, speed_source, vf_r, second_set_active, decel_stop,
    coast_stop, output_enable};
  wire logic rd_hit = (s_axi_araddr == `DIS_A_CTRL) ||
    (s_axi_araddr == `DIS_A_TF0) || (s_axi_araddr == `DIS_A_TF1) ||
    (s_axi_araddr == `DIS_A_NET) || (s_axi_araddr == `DIS_A_STAT) ||
    (s_axi_araddr == `DIS_A_PAR) || (s_axi_araddr == `DIS_A_MOT);
  wire logic [31:0] rd_word =
    (s_axi_araddr == `DIS_A_CTRL) ? ctrl_r :
    (s_axi_araddr == `DIS_A_TF0) ? tf0_r :
    (s_axi_araddr == `DIS_A_TF1) ? tf1_r :
    (s_axi_araddr == `DIS_A_NET) ? net_r :
    (s_axi_araddr == `DIS_A_STAT) ? stat_word :
    (s_axi_araddr == `DIS_A_PAR) ? {dec_par, acc_par} :
    (s_axi_araddr == `DIS_A_MOT) ? {16'h0000, mot_par} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DIS_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `DIS_AXI_OKAY : `DIS_AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage, masked by byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `DIS_CTRL_RST;
      tf0_r <= `DIS_TF_RST0;
      tf1_r <= `DIS_TF_RST1;
      net_r <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_r <= (ctrl_r & ~bmask) | (w_data_r & bmask);
      if (wr_tf0) tf0_r <= (tf0_r & ~bmask) | (w_data_r & bmask);
      if (wr_tf1) tf1_r <= (tf1_r & ~bmask) | (w_data_r & bmask);
      if (wr_net) net_r <= (net_r & ~bmask) | (w_data_r & bmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DIS_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `DIS_AXI_OKAY : `DIS_AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dis_top
`default_nettype wire

/* dis_top_assertions.sv */
// concurrent checks on the ports of the drive input signal block
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_top_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive state and outputs
  input wire logic drive_running,
  input wire logic output_enable,
  input wire logic coast_stop,
  input wire logic decel_stop,
  input wire logic second_set_active,
  input wire logic vf_control
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_coast_blocks_enable: assert property (
    coast_stop |-> !output_enable) else $error("enabled while coasting");
  a_decel_blocks_enable: assert property (
    decel_stop |-> !output_enable) else $error("enabled while ramping down");
  // a change launched before running is excluded
  a_vf_frozen_run: assert property (
    drive_running && $past(drive_running) && $past(aresetn)
    |-> $stable(vf_control)) else $error("control method changed in run");
  a_vf_pulls_second: assert property (
    $rose(vf_control) |-> second_set_active) else $error("vf without set 2");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  a_bvalid_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_bvalid_blocks: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data repeated");
  a_unmapped_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `DIS_AXI_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
endmodule // dis_top_assertions
`default_nettype wire

/* dis_contacts.sv */
// model of the switch contacts wired to the input terminals
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_contacts (
  // clock
  input wire logic aclk,
  // wanted contact state and bounce length in cycles
  input wire logic [`DIS_NTERM-1:0] want,
  input wire logic [7:0] chatter,
  // contact levels seen at the terminals
  output logic [`DIS_NTERM-1:0] pins
);
  logic [`DIS_NTERM-1:0] held_r = '0;
  logic [`DIS_NTERM-1:0] moved_r = '0;
  logic [7:0] cnt_r = 8'h00;
  // moved bits flip every other pair of cycles while bouncing
  always_ff @(posedge aclk) begin
    if (want != held_r) begin
      held_r <= want;
      moved_r <= want ^ held_r;
      cnt_r <= chatter;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign pins = cnt_r[1] ? (held_r ^ moved_r) : held_r;
endmodule // dis_contacts
`default_nettype wire

/* dis_top_bench.sv */
// self-checking bench of the drive input signal block
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_top_bench;
  logic aclk, aresetn, drive_running;
  logic [7:0] s_axi_awaddr, s_axi_araddr, chatter;
  logic [31:0] s_axi_wdata, s_axi_rdata, obs;
  logic [3:0] s_axi_wstrb, speed_step;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, output_enable, coast_stop, decel_stop;
  logic [1:0] s_axi_bresp, s_axi_rresp, speed_source;
  logic second_set_active, vf_control, remote_accel, remote_decel;
  logic remote_clear, voltage_input_valid, run_permit_ok;
  logic panel_interlock_active;
  logic [`DIS_NTERM-1:0] want, pins;
  int error_cnt, n_compared;
  dis_top i_dis_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .terminal_pin(pins), .drive_running(drive_running),
    .output_enable(output_enable), .coast_stop(coast_stop),
    .decel_stop(decel_stop), .second_set_active(second_set_active),
    .vf_control(vf_control), .speed_source(speed_source),
    .speed_step(speed_step), .remote_accel(remote_accel),
    .remote_decel(remote_decel), .remote_clear(remote_clear),
    .voltage_input_valid(voltage_input_valid),
    .run_permit_ok(run_permit_ok),
    .panel_interlock_active(panel_interlock_active));
  dis_contacts i_dis_contacts (.aclk(aclk), .want(want),
    .chatter(chatter), .pins(pins));
  assign obs = {15'h0000, panel_interlock_active, run_permit_ok,
    voltage_input_valid, remote_clear, remote_decel, remote_accel,
    speed_step, speed_source, vf_control, second_set_active, decel_stop,
    coast_stop, output_enable};
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [31:0] mask, input logic [31:0] exp);
    cmp_word(obs & mask, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // filter answers in about 2003 cycles, plus margin
  task automatic settle;
    tick(2100);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `DIS_AXI_OKAY);
    logic done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        cmp_resp(s_axi_bresp, er);
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = `DIS_AXI_OKAY);
    logic done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        cmp_word(s_axi_rdata, ed);
        cmp_resp(s_axi_rresp, er);
      end
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    tick(60000);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    int e, k, n;
    logic en;
    {aresetn, drive_running, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, chatter} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    want = '0;
    error_cnt = 0;
    n_compared = 0;
    tick(2);
    aresetn <= 1'b1;
    tick(3);
    rd(`DIS_A_CTRL, `DIS_CTRL_RST);
    rd(`DIS_A_TF0, `DIS_TF_RST0);
    rd(`DIS_A_TF1, `DIS_TF_RST1);
    rd(`DIS_A_NET, 32'h0000_0000);
    rd(`DIS_A_PAR, {`DIS_PR_DEC1, `DIS_PR_ACC1});
    rd(`DIS_A_MOT, {16'h0000, `DIS_PR_MOT1});
    rd(8'h1c, 32'h0000_0000, `DIS_AXI_SLVERR);
    wr(`DIS_A_STAT, 32'hffff_ffff, `DIS_AXI_SLVERR);
    chk(32'h0000_c003, 32'h0000_c000);
    $display("test reset values done");
    wr(`DIS_A_TF1, {24'h00_0000, `DIS_FN_SHUT});
    for (e = 0; e < 2; e++) begin
      want <= (e != 0) ? 5'h11 : 5'h01;
      settle();
      // modes 0..2 ride along; mode has no say in shutoff
      for (k = 0; k < 3; k++) begin
        for (n = 0; n < 2; n++) begin
          wr(`DIS_A_CTRL, 32'(18 * k));
          wr(`DIS_A_NET, 32'(n));
          tick(4);
          en = (k == 0) ? (e == 0 && n == 0) :
               (k == 1) ? (e == 1 && n == 1) : (e == 1 && n == 0);
          chk(32'h0000_0003, {30'h0, !en, en});
        end
      end
    end
    wr(`DIS_A_CTRL, 32'h0000_0074);
    wr(`DIS_A_NET, 32'h0000_0000);
    tick(4);
    chk(32'h0001_0003, 32'h0000_0001);
    wr(`DIS_A_NET, 32'h0000_0001);
    tick(4);
    chk(32'h0001_0003, 32'h0001_0002);
    wr(`DIS_A_NET, 32'h0000_0000);
    drive_running <= 1'b1;
    tick(4);
    chk(32'h0000_0003, 32'h0000_0001);
    wr(`DIS_A_NET, 32'h0000_0001);
    tick(2);
    chk(32'h0000_0007, 32'h0000_0002);
    wr(`DIS_A_NET, 32'h0000_0000);
    tick(4);
    want <= 5'h10;
    tick(1500);
    chk(32'h0000_0007, 32'h0000_0001);
    tick(600);
    chk(32'h0000_0007, 32'h0000_0004);
    drive_running <= 1'b0;
    $display("test output shutoff done");
    wr(`DIS_A_CTRL, 32'h0000_0000);
    wr(`DIS_A_NET, 32'h0000_0000);
    wr(`DIS_A_TF0, 32'h0202_3d3c);
    wr(`DIS_A_TF1, 32'h0000_0005);
    chatter <= 8'h40;
    want <= 5'h04;
    settle();
    chk(32'h0000_07e0, 32'h0000_0240);
    want <= 5'h08;
    settle();
    chk(32'h0000_07e0, 32'h0000_0240);
    want <= 5'h18;
    settle();
    chk(32'h0000_0060, 32'h0000_0060);
    wr(`DIS_A_TF1, 32'h0000_000e);
    tick(4);
    chk(32'h0000_0060, 32'h0000_0040);
    wr(`DIS_A_TF0, 32'h0303_3d3c);
    tick(4);
    chk(32'h0000_0068, 32'h0000_0028);
    rd(`DIS_A_PAR, {`DIS_PR_DEC2A, `DIS_PR_ACC2});
    wr(`DIS_A_CTRL, 32'h0000_0200);
    rd(`DIS_A_PAR, {`DIS_PR_DEC2B, `DIS_PR_ACC2});
    rd(`DIS_A_MOT, {16'h0000, `DIS_PR_MOT2});
    $display("test speed priority and second set done");
    wr(`DIS_A_CTRL, 32'h0000_0000);
    wr(`DIS_A_TF1, 32'h0000_0004);
    tick(4);
    chk(32'h0000_4000, 32'h0000_0000);
    wr(`DIS_A_TF1, 32'h0000_0000);
    tick(4);
    chk(32'h0000_4000, 32'h0000_4000);
    wr(`DIS_A_TF0, `DIS_TF_RST0);
    wr(`DIS_A_TF1, 32'h0000_0012);
    tick(4);
    chk(32'h0000_0018, 32'h0000_0018);
    drive_running <= 1'b1;
    wr(`DIS_A_TF1, 32'h0000_0000);
    tick(4);
    chk(32'h0000_0018, 32'h0000_0010);
    drive_running <= 1'b0;
    tick(4);
    chk(32'h0000_0018, 32'h0000_0000);
    drive_running <= 1'b1;
    wr(`DIS_A_TF1, 32'h0000_0012);
    tick(4);
    chk(32'h0000_0018, 32'h0000_0008);
    drive_running <= 1'b0;
    $display("test control method done");
    wr(`DIS_A_TF0, 32'h0202_3d3c);
    wr(`DIS_A_TF1, 32'h0000_0000);
    wr(`DIS_A_CTRL, 32'h0000_0100);
    tick(4);
    chk(32'h0000_3b80, 32'h0000_2800);
    wr(`DIS_A_CTRL, 32'h0000_0000);
    chatter <= 8'h00;
    want <= 5'h08;
    tick(200);
    want <= 5'h18;
    settle();
    chk(32'h0000_0780, 32'h0000_0280);
    $display("test remote and glitch done");
    wrap_up();
  end
endmodule // dis_top_bench
bind dis_top dis_top_assertions i_dis_top_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .drive_running(drive_running),
  .output_enable(output_enable), .coast_stop(coast_stop),
  .decel_stop(decel_stop), .second_set_active(second_set_active),
  .vf_control(vf_control));
`default_nettype wire
